// ===== rtl/repeater_cfg_ctrl.sv
// configuration-mode control: strap decode, per-lane registers, axi4-lite slave
// assumes strap levels come from analog comparators (async) and the eeprom
// loader shares mclk
`timescale 1ns/1ps
module repeater_cfg_ctrl #(
  parameter int LANES = repeater_cfg_pkg::N_LANES
) (
  input  wire logic                             mclk,           // 50 MHz clock
  input  wire logic                             arst_n,         // async reset, active low
  input  wire repeater_cfg_pkg::strap_bus_t     straps,         // four-level strap codes
  input  wire logic                             card_present_input, // async, high = present
  input  wire logic                             ee_ld_valid,    // eeprom loader write strobe
  input  wire logic [3:0]                       ee_ld_index,    // loader word index
  input  wire logic [31:0]                      ee_ld_data,     // loader word data
  input  wire logic [7:0]                       s_axi_awaddr,   // write address
  input  wire logic                             s_axi_awvalid,  // write address valid
  output logic                                  s_axi_awready,  // write address ready
  input  wire logic [31:0]                      s_axi_wdata,    // write data
  input  wire logic [3:0]                       s_axi_wstrb,    // byte enables
  input  wire logic                             s_axi_wvalid,   // write data valid
  output logic                                  s_axi_wready,   // write data ready
  output logic [1:0]                            s_axi_bresp,    // write response
  output logic                                  s_axi_bvalid,   // write response valid
  input  wire logic                             s_axi_bready,   // write response ready
  input  wire logic [7:0]                       s_axi_araddr,   // read address
  input  wire logic                             s_axi_arvalid,  // read address valid
  output logic                                  s_axi_arready,  // read address ready
  output logic [31:0]                           s_axi_rdata,    // read data
  output logic [1:0]                            s_axi_rresp,    // read response
  output logic                                  s_axi_rvalid,   // read data valid
  input  wire logic                             s_axi_rready,   // read data ready
  output repeater_cfg_pkg::lane_cfg_t [LANES-1:0] lane_cfg,     // applied per-lane settings
  output logic [1:0]                            rate_sel,       // applied rate mode
  output logic [1:0]                            term_sel,       // applied termination mode
  output logic [1:0]                            idle_thresh_sel, // applied idle threshold
  output logic [3:0]                            slave_address_inputs, // captured bus address
  output repeater_cfg_pkg::cfg_mode_t           cfg_mode        // active configuration source
);
  import repeater_cfg_pkg::*;

  if (LANES < 2 || LANES > 8 || LANES % 2 != 0) begin : g_bad_lanes
    $error("LANES must be even and between 2 and 8");
  end

  localparam int HALF = LANES / 2;

  // reset release through two flops
  logic rst_meta_ff;
  logic rst_n_ff;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // strap and presence synchronisers; straps are quasi-static
  strap_bus_t strap_meta_ff;
  strap_bus_t strap_ff;
  logic       prs_meta_ff;
  logic       prs_ff;
  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      strap_meta_ff <= '0;
      strap_ff      <= '0;
      prs_meta_ff   <= 1'b0;
      prs_ff        <= 1'b0;
    end else begin
      strap_meta_ff <= straps;  // R17
      strap_ff      <= strap_meta_ff;
      prs_meta_ff   <= card_present_input;
      prs_ff        <= prs_meta_ff;
    end
  end

  function automatic cfg_mode_t decode_mode(input strap_lvl_t lvl);
    unique case (lvl)
      LVL_LOW:  decode_mode = MODE_PIN;     // R1
      LVL_HIGH: decode_mode = MODE_SLAVE;   // R1
      default:  decode_mode = MODE_MASTER;  // R1
    endcase
  endfunction

  function automatic logic [1:0] decode_rate(input strap_lvl_t lvl);
    unique case (lvl)
      LVL_LOW:  decode_rate = RATE_GEN12;  // R6
      LVL_HIGH: decode_rate = RATE_GEN3;   // R6
      default:  decode_rate = RATE_AUTO;   // R6
    endcase
  endfunction

  function automatic logic [1:0] decode_term(input strap_lvl_t lvl);
    unique case (lvl)
      LVL_LOW:  decode_term = TERM_HIGHZ;  // R5
      LVL_HIGH: decode_term = TERM_LOWZ;   // R5
      default:  decode_term = TERM_AUTO;   // R5
    endcase
  endfunction

  // pin-mode lane setting for one side
  function automatic lane_cfg_t pin_lane(input strap_lvl_t hi, input strap_lvl_t lo,
                                         input strap_lvl_t dem);
    pin_lane          = LANE_RESET;
    pin_lane.eq       = EQ_PIN_TABLE[{hi, lo}];  // R13 R15 R16 R14
    pin_lane.dem      = dem;                     // R3
    pin_lane.output_swing_setting      = VOD_FOR_DEM[dem];        // R4
  endfunction

  function automatic lane_cfg_t lane_of_word(input logic [31:0] w);
    lane_of_word = '{w[LF_TD], w[LF_VOD +: 3], w[LF_DEM +: 2], w[LF_EQ +: 8]};
  endfunction
  function automatic logic [31:0] word_of_lane(input lane_cfg_t l);
    word_of_lane = '0;
    word_of_lane[LF_TD] = l.term_dis;
    word_of_lane[LF_VOD +: 3] = l.output_swing_setting;
    word_of_lane[LF_DEM +: 2] = l.dem;
    word_of_lane[LF_EQ +: 8] = l.eq;
  endfunction

  wire cfg_mode_t mode_now   = decode_mode(strap_ff.mode);
  wire logic      is_pin     = (mode_now == MODE_PIN);
  wire logic      is_slave   = (mode_now == MODE_SLAVE);
  wire logic      is_master  = (mode_now == MODE_MASTER);
  // card present in slave mode freezes the register contents
  wire logic      reg_frozen = is_slave & prs_ff;  // R12

  wire lane_cfg_t pin_a = pin_lane(strap_ff.eq_a_hi, strap_ff.eq_a_lo, strap_ff.dem_a);
  wire lane_cfg_t pin_b = pin_lane(strap_ff.eq_b_hi, strap_ff.eq_b_lo, strap_ff.dem_b);
  wire logic [3:0] addr_pins = {strap_ff.eq_b_hi == LVL_HIGH, strap_ff.eq_b_lo == LVL_HIGH,
                                strap_ff.eq_a_hi == LVL_HIGH, strap_ff.eq_a_lo == LVL_HIGH};

  // register file
  lane_cfg_t [LANES-1:0] lane_reg_ff;
  logic [10:0]           ctrl_ff;

  // axi write path: address and data taken together, one write in flight
  logic       awready_ff;
  logic       bvalid_ff;
  logic [1:0] bresp_ff;
  wire logic  wr_take   = s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
  wire logic  wr_fire   = awready_ff;
  wire logic [5:0] wr_word = s_axi_awaddr[7:2];
  wire logic  wr_lane   = (s_axi_awaddr[1:0] == 2'b00) && (wr_word < 6'(LANES));
  wire logic  wr_ctrl   = (s_axi_awaddr == OFS_CTRL);
  wire logic  wr_ok     = (wr_lane | wr_ctrl) & is_slave & ~reg_frozen;
  wire logic [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                             {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // loader path, used only while the mode strap is open or at the resistor level
  wire logic  ld_lane = is_master & ee_ld_valid & ({2'b00, ee_ld_index} < 6'(LANES));  // R2
  wire logic  ld_ctrl = is_master & ee_ld_valid & (ee_ld_index == 4'(OFS_CTRL >> 2));   // R2

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      awready_ff <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      awready_ff <= wr_take;
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // lane registers: one word each, reset whenever pin mode is selected
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    wire logic [31:0] cur   = word_of_lane(lane_reg_ff[i]);
    wire logic [31:0] merged = (s_axi_wdata & wmask) | (cur & ~wmask);
    wire logic        hit_axi = wr_fire & wr_ok & wr_lane & (wr_word == 6'(i));
    wire logic        hit_ld  = ld_lane & (ee_ld_index == 4'(i)) & ~reg_frozen;
    wire lane_cfg_t   nxt_lane = hit_axi ? lane_of_word(merged) :
                                 hit_ld  ? lane_of_word(ee_ld_data) : lane_reg_ff[i];
    always_ff @(posedge mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        lane_reg_ff[i] <= LANE_RESET;  // R11
      end else if (is_pin) begin
        lane_reg_ff[i] <= LANE_RESET;  // R11
      end else begin
        lane_reg_ff[i] <= nxt_lane;    // R7
      end
    end
  end

  wire logic [31:0] ctrl_cur    = {21'h000000, ctrl_ff};
  wire logic [31:0] ctrl_merged = (s_axi_wdata & wmask) | (ctrl_cur & ~wmask);
  wire logic [10:0] nxt_ctrl    = (wr_fire & wr_ok & wr_ctrl) ? ctrl_merged[10:0] :
                                  (ld_ctrl & ~reg_frozen)     ? ee_ld_data[10:0]  : ctrl_ff;

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ctrl_ff <= CTRL_RESET;  // R11
    end else if (is_pin) begin
      ctrl_ff <= CTRL_RESET;  // R11 R10
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // overrides only count outside pin mode; reset clears them on pin re-entry
  wire logic [1:0] eff_rate = (!is_pin && ctrl_ff[CF_RATE_OVR]) ?
                              ctrl_ff[CF_RATE +: 2] : decode_rate(strap_ff.rate);    // R10 R6
  wire logic [1:0] eff_term = (!is_pin && ctrl_ff[CF_RECEIVER_DETECT_CONTROL_OVR]) ?
                              ctrl_ff[CF_RECEIVER_DETECT_CONTROL +: 2] : decode_term(strap_ff.receiver_detect_control);  // R10 R5
  wire logic [1:0] eff_sdth = (!is_pin && ctrl_ff[CF_SDTH_OVR]) ?
                              ctrl_ff[CF_SDTH +: 2] : 2'(strap_ff.idle_detect_threshold_strap);            // R10

  // axi read path
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  wire logic   rd_take = s_axi_arvalid & ~arready_ff & ~rvalid_ff;
  wire logic [5:0] rd_word = s_axi_araddr[7:2];
  wire logic   rd_lane = (s_axi_araddr[1:0] == 2'b00) && (rd_word < 6'(LANES));
  wire logic [2:0] rd_lane_idx = rd_word[2:0];
  wire logic [31:0] status_word = {18'h00000, eff_sdth, eff_term, eff_rate,
                                   slave_address_inputs, prs_ff, mode_now};
  wire logic [31:0] rd_lane_word = word_of_lane(lane_reg_ff[rd_lane_idx]);
  wire logic [31:0] rd_data = rd_lane                       ? rd_lane_word :
                              (s_axi_araddr == OFS_CTRL)    ? ctrl_cur :
                              (s_axi_araddr == OFS_STATUS)  ? status_word : 32'h0000_0000;
  wire logic   rd_ok   = rd_lane | (s_axi_araddr == OFS_CTRL) | (s_axi_araddr == OFS_STATUS);

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else begin
      arready_ff <= rd_take;
      if (rd_take) begin
        rdata_ff <= rd_data;
        rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (arready_ff) begin
        rvalid_ff <= 1'b1;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // applied outputs: source switches the cycle after the mode change is seen
  lane_cfg_t [LANES-1:0] lane_out_ff;
  logic [1:0]            rate_ff;
  logic [1:0]            term_ff;
  logic [1:0]            sdth_ff;
  logic [3:0]            addr_ff;
  cfg_mode_t             mode_ff;

  for (genvar i = 0; i < LANES; i++) begin : g_out
    wire lane_cfg_t nxt_out = is_pin ? ((i < HALF) ? pin_a : pin_b)  // R3
                                     : lane_reg_ff[i];               // R8 R7
    always_ff @(posedge mclk or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        lane_out_ff[i] <= LANE_RESET;
      end else begin
        lane_out_ff[i] <= nxt_out;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rate_ff <= RATE_GEN12;
      term_ff <= TERM_AUTO;
      sdth_ff <= 2'h0;
      addr_ff <= 4'h0;
      mode_ff <= MODE_PIN;
    end else begin
      rate_ff <= eff_rate;
      term_ff <= eff_term;
      sdth_ff <= eff_sdth;
      if (is_slave) begin
        addr_ff <= addr_pins;  // R9
      end
      mode_ff <= mode_now;     // R17
    end
  end

  assign lane_cfg             = lane_out_ff;
  assign rate_sel             = rate_ff;
  assign term_sel             = term_ff;
  assign idle_thresh_sel      = sdth_ff;
  assign slave_address_inputs = addr_ff;
  assign cfg_mode             = mode_ff;
  assign s_axi_awready        = awready_ff;
  assign s_axi_wready         = awready_ff;
  assign s_axi_bvalid         = bvalid_ff;
  assign s_axi_bresp          = bresp_ff;
  assign s_axi_arready        = arready_ff;
  assign s_axi_rvalid         = rvalid_ff;
  assign s_axi_rdata          = rdata_ff;
  assign s_axi_rresp          = rresp_ff;

endmodule

// ===== rtl/repeater_cfg_pkg.sv
// constants, field layouts and carrier types for the repeater configuration block
// assumes the four-level strap sensing is done outside and arrives as 2-bit level codes
// Notes on behaviour
// R1: mode strap low selects pins, high selects bus slave, open selects bus master.
// R2: open mode strap: settings are loaded from an external EEPROM by the master.
// R3: pin mode takes equalization and de-emphasis from straps, side A and B separately.
// R4: pin mode with nonzero de-emphasis adjusts output swing to match that level.
// R5: receiver-detect strap selects automatic detect, or manual low or high impedance.
// R6: rate strap selects fixed gen1/2, automatic rate detect, or fixed gen3.
// R7: slave mode holds swing, equalization, de-emphasis and termination-disable per lane.
// R8: mode strap high switches equalization and de-emphasis to registers at once.
// R9: slave mode reuses equalization and de-emphasis straps as four address inputs; the code takes only the four equalization straps.
// R10: rate, detect, threshold straps rule in slave mode unless register override set.
// R11: all configuration registers return to defaults at power-up and mode strap low.
// R12: card present asserted while mode strap high keeps register contents unchanged.
// R13: each input has an 8-bit equalization code; straps reach only 16 settings.
// R14: with mode strap low each strap decodes into four levels.
// R15: equalization strap pair both low gives 0x00; high low, low resistor gives 0x01.
// R16: equalization strap pair high low, low open gives code 0x02.
// R17: mode strap is sampled continuously; any change selects the new source.
package repeater_cfg_pkg;

  localparam int N_LANES = 8;

  // four-level strap codes as delivered by the sensing comparators
  typedef enum logic [1:0] {
    LVL_LOW   = 2'h0,
    LVL_RES   = 2'h1,
    LVL_OPEN  = 2'h2,
    LVL_HIGH  = 2'h3
  } strap_lvl_t;

  typedef enum logic [2:0] {
    MODE_PIN    = 3'b001,
    MODE_SLAVE  = 3'b010,
    MODE_MASTER = 3'b100
  } cfg_mode_t;

  localparam logic [1:0] RATE_GEN12 = 2'h0;
  localparam logic [1:0] RATE_AUTO  = 2'h1;
  localparam logic [1:0] RATE_GEN3  = 2'h2;
  localparam logic [1:0] TERM_AUTO  = 2'h0;
  localparam logic [1:0] TERM_LOWZ  = 2'h1;
  localparam logic [1:0] TERM_HIGHZ = 2'h2;

  typedef struct packed {
    strap_lvl_t mode;
    strap_lvl_t eq_a_hi;
    strap_lvl_t eq_a_lo;
    strap_lvl_t eq_b_hi;
    strap_lvl_t eq_b_lo;
    strap_lvl_t dem_a;
    strap_lvl_t dem_b;
    strap_lvl_t rate;
    strap_lvl_t receiver_detect_control;
    strap_lvl_t idle_detect_threshold_strap;
  } strap_bus_t;

  typedef struct packed {
    logic       term_dis;
    logic [2:0] output_swing_setting;
    logic [1:0] dem;
    logic [7:0] eq;
  } lane_cfg_t;

  // register byte offsets
  localparam logic [7:0] OFS_LANE0  = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_LAST   = 8'h24;

  // lane register fields
  localparam int LF_EQ  = 0;
  localparam int LF_DEM = 8;
  localparam int LF_VOD = 12;
  localparam int LF_TD  = 16;
  // control register fields
  localparam int CF_RATE      = 0;
  localparam int CF_RATE_OVR  = 2;
  localparam int CF_RECEIVER_DETECT_CONTROL     = 4;
  localparam int CF_RECEIVER_DETECT_CONTROL_OVR = 6;
  localparam int CF_SDTH      = 8;
  localparam int CF_SDTH_OVR  = 10;
  // status register fields
  localparam int SF_MODE    = 0;
  localparam int SF_PRESENT = 3;
  localparam int SF_ADDR    = 4;
  localparam int SF_RATE    = 8;
  localparam int SF_RECEIVER_DETECT_CONTROL   = 10;
  localparam int SF_SDTH    = 12;

  localparam logic [2:0] VOD_DEFAULT = 3'h2;
  localparam lane_cfg_t  LANE_RESET  = '{term_dis: 1'b0, output_swing_setting: VOD_DEFAULT,
                                        dem: 2'h0, eq: 8'h00};
  localparam logic [10:0] CTRL_RESET = 11'h000;

  // equalization code by {high strap, low strap} level, 16 of 256 codes
  localparam logic [15:0][7:0] EQ_PIN_TABLE = {
    8'hff, 8'hbf, 8'h7f, 8'haa, 8'h3f, 8'h2f, 8'h1f, 8'h55,
    8'h0f, 8'h0b, 8'h15, 8'h07, 8'h03, 8'h02, 8'h01, 8'h00};
  // output swing matched to each de-emphasis level
  localparam logic [3:0][2:0] VOD_FOR_DEM = {3'h5, 3'h4, 3'h3, VOD_DEFAULT};

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ===== tb/repeater_cfg_ctrl_asserts.sv
// checker for the repeater configuration block: mode, strap decode, refusals
// assumes it is bound onto repeater_cfg_ctrl and sees only its ports
`timescale 1ns/1ps
module repeater_cfg_ctrl_asserts #(
  parameter int LANES = repeater_cfg_pkg::N_LANES
) (
  input logic                                   mclk,                 // clock
  input logic                                   arst_n,               // async reset
  input repeater_cfg_pkg::strap_bus_t           straps,               // strap levels
  input logic                                   card_present_input,   // card present
  input logic                                   s_axi_awready,        // write taken
  input logic                                   s_axi_bvalid,         // write answer
  input logic [1:0]                             s_axi_bresp,          // write status
  input repeater_cfg_pkg::lane_cfg_t [LANES-1:0] lane_cfg,            // lane settings
  input logic [1:0]                             rate_sel,             // rate mode
  input logic [1:0]                             term_sel,             // termination
  input logic [3:0]                             slave_address_inputs, // bus address
  input repeater_cfg_pkg::cfg_mode_t            cfg_mode              // config source
);
  import repeater_cfg_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // eight stable samples cover sync delay plus the reset tail
  property p_mode_pin; (straps.mode == LVL_LOW) [*8] |-> cfg_mode == MODE_PIN; endproperty
  a_mode_pin: assert property (p_mode_pin) else $error("pin mode missed");
  property p_mode_slave; (straps.mode == LVL_HIGH) [*8] |-> cfg_mode == MODE_SLAVE; endproperty
  a_mode_slave: assert property (p_mode_slave) else $error("slave mode missed");
  property p_mode_mst; (straps.mode == LVL_OPEN) [*8] |-> cfg_mode == MODE_MASTER; endproperty
  a_mode_mst: assert property (p_mode_mst) else $error("master mode missed");
  property p_rate; (straps.mode == LVL_LOW && straps.rate == LVL_HIGH) [*8]
    |-> rate_sel == RATE_GEN3; endproperty
  a_rate: assert property (p_rate) else $error("rate strap ignored");
  property p_term; (straps.mode == LVL_LOW && straps.receiver_detect_control == LVL_LOW) [*8]
    |-> term_sel == TERM_HIGHZ; endproperty
  a_term: assert property (p_term) else $error("detect strap ignored");
  property p_eq0; (straps.mode == LVL_LOW && straps.eq_a_hi == LVL_LOW
    && straps.eq_a_lo == LVL_LOW) [*8] |-> lane_cfg[0].eq == 8'h00; endproperty
  a_eq0: assert property (p_eq0) else $error("eq strap code wrong");
  property p_vod; (cfg_mode == MODE_PIN && $past(cfg_mode) == MODE_PIN && lane_cfg[0].dem != 2'h0)
    |-> lane_cfg[0].output_swing_setting == VOD_FOR_DEM[lane_cfg[0].dem]; endproperty
  a_vod: assert property (p_vod) else $error("swing not matched");
  property p_addr; (cfg_mode != MODE_SLAVE) ##1 (cfg_mode != MODE_SLAVE)
    |-> $stable(slave_address_inputs); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_pin_ref; (s_axi_awready && cfg_mode == MODE_PIN)
    |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR; endproperty
  a_pin_ref: assert property (p_pin_ref) else $error("pin mode write taken");
  property p_frz; (card_present_input [*5] ##0 (s_axi_awready && cfg_mode == MODE_SLAVE))
    |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR; endproperty
  a_frz: assert property (p_frz) else $error("frozen write taken");
  c_slv_wr: cover property (s_axi_awready && cfg_mode == MODE_SLAVE);
  c_mst: cover property (cfg_mode == MODE_MASTER);
  c_frz: cover property (card_present_input && s_axi_awready);
endmodule

// ===== tb/strap_board.sv
// board model: strap resistors and card-present line at the repeater
// assumes the bench calls its tasks; levels move just after a rising edge
`timescale 1ns/1ps
module strap_board (
  input  logic                         mclk,    // clock
  output repeater_cfg_pkg::strap_bus_t straps,  // strap levels
  output logic                         present  // card present
);
  import repeater_cfg_pkg::*;
  logic [19:0] lv = 20'h00000;
  assign straps = strap_bus_t'(lv);
  initial present = 1'b0;
  // only the four legal levels ever reach a strap
  task automatic set_lvl(input int k, input strap_lvl_t v);
    @(posedge mclk);
    lv[19-2*k -: 2] <= v;
  endtask
  task automatic card(input logic v);
    @(posedge mclk);
    present <= v;
  endtask
endmodule

// ===== tb/tb_top.sv
// bench for the repeater configuration block: modes, strap decode, registers
// assumes a 50 MHz mclk and the strap board model beside the design
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
  $display("Error t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import repeater_cfg_pkg::*;
  localparam int LANES = 8;
  localparam int S_MODE = 0, S_EQAH = 1, S_EQAL = 2, S_EQBL = 4, S_DEMA = 5;
  localparam int S_RATE = 7, S_RECEIVER_DETECT_CONTROL = 8, S_SDTH = 9;
  logic                   mclk = 1'b0, arst_n = 1'b0, card_present_input;
  logic                   ee_ld_valid = 1'b0;
  logic [3:0]             ee_ld_index = 4'h0, slave_address_inputs;
  logic [31:0]            ee_ld_data = 32'h0, s_axi_wdata = 32'h0, s_axi_rdata;
  logic [7:0]             s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic                   s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                   s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]             s_axi_bresp, s_axi_rresp, rate_sel, term_sel, idle_thresh_sel;
  strap_bus_t             straps;
  lane_cfg_t [LANES-1:0]  lane_cfg;
  cfg_mode_t              cfg_mode;
  int                     fails = 0, samples_checked = 0;
  always #10 mclk = ~mclk;
  strap_board u_board (.mclk(mclk), .straps(straps), .present(card_present_input));
  repeater_cfg_ctrl #(.LANES(LANES)) u_dut (
    .mclk(mclk), .arst_n(arst_n), .straps(straps), .card_present_input(card_present_input),
    .ee_ld_valid(ee_ld_valid), .ee_ld_index(ee_ld_index), .ee_ld_data(ee_ld_data),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .lane_cfg(lane_cfg),
    .rate_sel(rate_sel), .term_sel(term_sel), .idle_thresh_sel(idle_thresh_sel),
    .slave_address_inputs(slave_address_inputs), .cfg_mode(cfg_mode));
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    test_done;
  end
  initial begin
    strap_lvl_t lv[4];
    logic [1:0] er[4], et[4];
    lv = '{LVL_LOW, LVL_RES, LVL_OPEN, LVL_HIGH};
    er = '{RATE_GEN12, RATE_AUTO, RATE_AUTO, RATE_GEN3};
    et = '{TERM_HIGHZ, TERM_AUTO, TERM_AUTO, TERM_LOWZ};
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    wt(10);
    `CHK(cfg_mode, MODE_PIN)
    `CHK(lane_cfg[0].eq, 8'h00)
    u_board.set_lvl(S_EQBL, LVL_RES);
    u_board.set_lvl(S_EQAL, LVL_OPEN);
    wt(8);
    `CHK(lane_cfg[7].eq, 8'h01)
    `CHK(lane_cfg[3].eq, 8'h02)
    `CHK(lane_cfg[4].eq, 8'h01)
    for (int d = 0; d < 4; d++) begin
      u_board.set_lvl(S_DEMA, strap_lvl_t'(d));
      wt(8);
      `CHK(lane_cfg[0].dem, 2'(d))
      `CHK(lane_cfg[0].output_swing_setting, VOD_FOR_DEM[d])
      `CHK(lane_cfg[4].dem, 2'h0)
    end
    for (int i = 0; i < 4; i++) begin
      u_board.set_lvl(S_RATE, lv[i]);
      u_board.set_lvl(S_RECEIVER_DETECT_CONTROL, lv[i]);
      wt(8);
      `CHK(rate_sel, er[i])
      `CHK(term_sel, et[i])
    end
    axi_wr(OFS_LANE0, 32'h0001_1fff, RESP_SLVERR);
    u_board.set_lvl(S_SDTH, LVL_OPEN);
    u_board.set_lvl(S_EQAH, LVL_HIGH);
    u_board.set_lvl(S_EQBL, LVL_HIGH);
    u_board.set_lvl(S_MODE, LVL_HIGH);
    wt(8);
    `CHK(cfg_mode, MODE_SLAVE)
    `CHK(slave_address_inputs, 4'h6)
    `CHK(lane_cfg[0], LANE_RESET)
    `CHK(idle_thresh_sel, 2'h2)
    axi_rd(OFS_LANE0, 32'h0000_2000, RESP_OKAY);
    axi_wr(OFS_LANE0 + 8'h0c, 32'h0001_61a5, RESP_OKAY);
    axi_wr(OFS_LANE0 + 8'h10, 32'h0000_32c3, RESP_OKAY);
    wt(2);
    `CHK(lane_cfg[3], lane_cfg_t'({1'b1, 3'h6, 2'h1, 8'ha5}))
    `CHK(lane_cfg[4], lane_cfg_t'({1'b0, 3'h3, 2'h2, 8'hc3}))
    `CHK(lane_cfg[2], LANE_RESET)
    axi_rd(OFS_LANE0 + 8'h0c, 32'h0001_61a5, RESP_OKAY);
    axi_rd(8'h28, 32'h0, RESP_SLVERR);
    axi_wr(OFS_STATUS, 32'hffff_ffff, RESP_SLVERR);
    axi_wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    wt(2);
    `CHK(rate_sel, RATE_GEN3)
    axi_wr(OFS_CTRL, 32'h0000_0564, RESP_OKAY);
    u_board.set_lvl(S_RATE, LVL_OPEN);
    wt(8);
    `CHK(rate_sel, RATE_GEN12)
    `CHK(idle_thresh_sel, 2'h1)
    `CHK(term_sel, TERM_HIGHZ)
    u_board.card(1'b1);
    wt(4);
    axi_wr(OFS_LANE0 + 8'h0c, 32'h0, RESP_SLVERR);
    wt(2);
    `CHK(lane_cfg[3].eq, 8'ha5)
    u_board.card(1'b0);
    u_board.set_lvl(S_MODE, LVL_LOW);
    wt(8);
    `CHK(cfg_mode, MODE_PIN)
    `CHK(rate_sel, RATE_AUTO)
    u_board.set_lvl(S_MODE, LVL_HIGH);
    wt(8);
    axi_rd(OFS_LANE0 + 8'h0c, 32'h0000_2000, RESP_OKAY);
    axi_rd(OFS_CTRL, 32'h0, RESP_OKAY);
    `CHK(rate_sel, RATE_AUTO)
    u_board.set_lvl(S_MODE, LVL_OPEN);
    wt(8);
    `CHK(cfg_mode, MODE_MASTER)
    @(posedge mclk);
    ee_ld_valid <= 1'b1;
    ee_ld_index <= 4'h2;
    ee_ld_data <= 32'h0001_43c0;
    @(posedge mclk);
    ee_ld_valid <= 1'b0;
    wt(3);
    `CHK(lane_cfg[2], lane_cfg_t'({1'b1, 3'h4, 2'h3, 8'hc0}))
    axi_wr(OFS_LANE0, 32'h1, RESP_SLVERR);
    u_board.set_lvl(S_MODE, LVL_RES);
    wt(8);
    `CHK(cfg_mode, MODE_MASTER)
    test_done;
  end
endmodule
bind repeater_cfg_ctrl repeater_cfg_ctrl_asserts #(.LANES(LANES)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .straps(straps), .card_present_input(card_present_input),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .lane_cfg(lane_cfg), .rate_sel(rate_sel), .term_sel(term_sel),
  .slave_address_inputs(slave_address_inputs), .cfg_mode(cfg_mode));
